// ===== hdl/csa_core.sv
// Our own choices: the Wishbone interface to the registers and the placing of the registers not fixed by RL19.
`timescale 1ns/1ps
`default_nettype none
`include "csa_map.svh"
module csa_core #(
  parameter int PC_W = 11,
  parameter int GP_DEPTH = 32
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [8:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_step,
  input wire logic i_wdt_timeout,
  output logic [PC_W-1:0] o_pc,
  output logic o_dummy,
  output logic [7:0] o_acc,
  output logic [7:0] o_status
);
  localparam int MEM_N = 2 * GP_DEPTH;

  // bus slave state
  logic ack_q, ack_d;
  logic [7:0] rdat_q, rdat_d;

  // core state
  logic [7:0] acc_q, acc_d;
  csa_pkg::csa_flags_s flg_q, flg_d;
  logic to_q, to_d;
  logic pdf_q, pdf_d;
  logic [7:0] mp0_q, mp0_d;
  logic [7:0] mp1_q, mp1_d;
  logic bank_q, bank_d;
  logic [PC_W-1:0] pc_q, pc_d;
  logic pend_q, pend_d;
  logic dummy_q, dummy_d;

  // data memory, two banks of general purpose bytes
  logic [7:0] mem_q [MEM_N];
  logic mem_we;
  logic [$clog2(MEM_N)-1:0] mem_wa;
  logic [7:0] mem_wd;

  logic [6:0] idx;
  logic commit;
  logic bus_wr;
  logic is_cmd;
  csa_pkg::csa_op_e cmd_op;
  logic [6:0] cmd_idx;
  logic [7:0] cmd_m;
  logic [7:0] bus_rd;
  csa_pkg::csa_alu_s alu;

  // wishbone word index, low 8 data bits carry the register
  assign idx = i_wb_adr[8:2];
  assign commit = i_wb_cyc && i_wb_stb && ack_q;
  assign bus_wr = commit && i_wb_we && i_wb_sel[0];
  assign is_cmd = (idx == `CSA_IDX_CMD);
  assign cmd_op = csa_pkg::csa_op_e'(i_wb_dat[3:0]);
  assign cmd_idx = i_wb_dat[14:8];

  // indirect ports resolve to {bank, index} through their pointer
  function automatic logic [7:0] resolve(input logic [6:0] a);
    logic [7:0] r;
    r = {1'b0, a};
    if (a == `CSA_IDX_INDIRECT_PORT_ZERO) begin
      r = {1'b0, mp0_q[6:0]}; // [RL17] [RL18]
    end else if (a == `CSA_IDX_INDIRECT_PORT_ONE) begin
      r = {bank_q, mp1_q[6:0]}; // [RL17] [RL18]
    end
    return r;
  endfunction

  function automatic logic gp_hit(input logic [6:0] a);
    return (a >= `CSA_IDX_GP_BASE) &&
      ({25'h0, a} < {25'h0, `CSA_IDX_GP_BASE} + GP_DEPTH);
  endfunction

  function automatic logic [$clog2(MEM_N)-1:0] gp_addr(
    input logic [7:0] ba);
    logic [6:0] off;
    off = ba[6:0] - `CSA_IDX_GP_BASE;
    return $clog2(MEM_N)'({ba[7], off[$clog2(GP_DEPTH)-1:0]});
  endfunction

  // read view of the data memory; an indirect port read back
  // through a pointer returns zero since it holds no storage
  function automatic logic [7:0] rd(input logic [7:0] ba);
    logic [7:0] v;
    v = 8'h00;
    case (ba[6:0])
      `CSA_IDX_MP0: v = mp0_q;
      `CSA_IDX_MP1: v = mp1_q;
      `CSA_IDX_BANK: v = {7'h00, bank_q};
      `CSA_IDX_ACC: v = acc_q; // [RL19]
      `CSA_IDX_PCL: v = pc_q[7:0]; // [RL19]
      `CSA_IDX_STATUS: v = {2'b00, to_q, pdf_q, flg_q}; // [RL11] [RL10]
      default: begin
        if (gp_hit(ba[6:0])) begin
          v = mem_q[gp_addr(ba)];
        end
      end
    endcase
    return v;
  endfunction

  // a process, not an assign: the lookups read state outside their
  // arguments and must follow every change of it
  always_comb begin
    bus_rd = rd(resolve(idx));
    cmd_m = rd(resolve(cmd_idx));
  end

  csa_alu u_alu (
    .i_op(cmd_op),
    .i_a(acc_q),
    .i_m(cmd_m),
    .i_c(flg_q.c),
    .o_out(alu)
  );

  // bus slave: ack one cycle after the request, dropped after one
  always_comb begin
    ack_d = i_wb_cyc && i_wb_stb && !ack_q;
    rdat_d = rdat_q;
    if (i_wb_cyc && i_wb_stb && !ack_q) begin
      rdat_d = is_cmd ? 8'h00 : bus_rd;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ack_q <= 1'b0;
      rdat_q <= 8'h00;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  // core next state: one write target per committed access
  always_comb begin
    logic [7:0] wt;
    logic [7:0] wd;
    logic wv;
    wt = 8'h00;
    wd = 8'h00;
    wv = 1'b0;
    acc_d = acc_q;
    flg_d = flg_q;
    to_d = to_q;
    pdf_d = pdf_q;
    mp0_d = mp0_q;
    mp1_d = mp1_q;
    bank_d = bank_q;
    pc_d = pc_q;
    pend_d = pend_q;
    dummy_d = 1'b0;
    mem_we = 1'b0;
    mem_wa = '0;
    mem_wd = 8'h00;
    if (i_step) begin
      if (pend_q) begin
        pend_d = 1'b0;
        dummy_d = 1'b1; // [RL4]
      end else begin
        pc_d = pc_q + PC_W'(1);
      end
    end
    if (bus_wr && !is_cmd) begin
      wt = resolve(idx);
      wd = i_wb_dat[7:0];
      wv = 1'b1;
    end
    if (bus_wr && is_cmd) begin
      // memory to memory goes as load then store via the accumulator
      if (cmd_op == csa_pkg::CSA_OP_STA) begin
        wt = resolve(cmd_idx); // [RL2]
        wd = acc_q;
        wv = 1'b1;
      end
      if (alu.wr_acc) begin
        acc_d = alu.res; // [RL1]
      end
      if (alu.upd.c) flg_d.c = alu.flags.c; // [RL12] [RL15]
      if (alu.upd.ac) flg_d.ac = alu.flags.ac; // [RL16]
      if (alu.upd.z) flg_d.z = alu.flags.z; // [RL14]
      if (alu.upd.ov) flg_d.ov = alu.flags.ov; // [RL13]
      if (cmd_op == csa_pkg::CSA_OP_CLRWDT) begin
        to_d = 1'b0; // [RL7]
        pdf_d = 1'b0; // [RL8]
      end
      if (cmd_op == csa_pkg::CSA_OP_HALT) begin
        to_d = 1'b0; // [RL7]
        pdf_d = 1'b1; // [RL8]
      end
    end
    if (wv) begin
      case (wt[6:0])
        `CSA_IDX_MP0: mp0_d = wd;
        `CSA_IDX_MP1: mp1_d = wd;
        `CSA_IDX_BANK: bank_d = wd[0];
        `CSA_IDX_ACC: acc_d = wd; // [RL19]
        `CSA_IDX_PCL: begin
          pc_d = {pc_q[PC_W-1:8], wd}; // [RL3]
          pend_d = 1'b1; // [RL4]
        end
        `CSA_IDX_STATUS: begin
          // the two system flags are kept, only the low four change
          flg_d = csa_pkg::csa_flags_s'(wd[3:0]); // [RL6] [RL10]
        end
        default: begin
          if (gp_hit(wt[6:0])) begin
            mem_we = 1'b1;
            mem_wa = gp_addr(wt);
            mem_wd = wd;
          end
        end
      endcase
    end
    // a timeout in the same cycle as a clear wins
    if (i_wdt_timeout) begin
      to_d = 1'b1; // [RL7]
    end
  end

  // calls and interrupts have no path into this state [RL9]
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      acc_q <= `CSA_ACC_RST;
      flg_q <= csa_pkg::csa_flags_s'(4'h0);
      to_q <= 1'b0; // [RL7]
      pdf_q <= 1'b0; // [RL8]
      mp0_q <= 8'h00;
      mp1_q <= 8'h00;
      bank_q <= 1'b0;
      pc_q <= '0;
      pend_q <= 1'b0;
      dummy_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      flg_q <= flg_d;
      to_q <= to_d;
      pdf_q <= pdf_d;
      mp0_q <= mp0_d;
      mp1_q <= mp1_d;
      bank_q <= bank_d;
      pc_q <= pc_d;
      pend_q <= pend_d;
      dummy_q <= dummy_d;
    end
  end

  // memory contents are not reset, like the general purpose ram
  always_ff @(posedge i_clk) begin
    if (mem_we) begin
      mem_q[mem_wa] <= mem_wd;
    end
  end

  assign o_wb_ack = ack_q;
  assign o_wb_dat = {24'h000000, rdat_q};
  assign o_pc = pc_q;
  assign o_dummy = dummy_q;
  assign o_acc = acc_q;
  assign o_status = {2'b00, to_q, pdf_q, flg_q}; // [RL5] [RL11]
endmodule
`default_nettype wire

// ===== shared/csa_map.svh
// Contract
// RL1 - alu results always land in the accumulator
// RL2 - register to register moves pass through accumulator
// RL3 - program counter low byte write jumps in page
// RL4 - counter low byte write inserts one dummy cycle
// RL5 - 8-bit flag register, c ac z ov at 0-3
// RL6 - flag writes never touch watchdog or sleep flags
// RL7 - watchdog flag: power-up/clear/halt clear, timeout sets
// RL8 - sleep flag: power-up/clear clear it, halt sets
// RL9 - flags never saved automatically on call or interrupt
// RL10 - four low flag bits readable and writable
// RL11 - flag bits 7 and 6 read zero
// RL12 - alu operations refresh zero, overflow, half, carry; here logic ops refresh zero only, rotates carry only, loads none
// RL13 - overflow: carry into msb differs from carry out
// RL14 - zero set when result is zero
// RL15 - carry: add carry out, sub no borrow, rotates
// RL16 - half carry: low nibble carry or no borrow
// RL17 - indirect ports act on location held by pointer
// RL18 - pointer zero bank 0 only, pointer one both
// RL19 - accumulator 05H, counter low 06H, flags 0AH
`ifndef CSA_MAP_SVH
`define CSA_MAP_SVH
`define CSA_IDX_INDIRECT_PORT_ZERO 7'h00
`define CSA_IDX_MP0 7'h01
`define CSA_IDX_INDIRECT_PORT_ONE 7'h02
`define CSA_IDX_MP1 7'h03
`define CSA_IDX_BANK 7'h04
`define CSA_IDX_ACC 7'h05
`define CSA_IDX_PCL 7'h06
`define CSA_IDX_STATUS 7'h0A
`define CSA_IDX_GP_BASE 7'h40
`define CSA_IDX_CMD 7'h60
`define CSA_BIT_C 0
`define CSA_BIT_AC 1
`define CSA_BIT_Z 2
`define CSA_BIT_OV 3
`define CSA_BIT_PDF 4
`define CSA_BIT_TO 5
`define CSA_STATUS_RST 8'h00
`define CSA_ACC_RST 8'h00
`define CSA_DUMMY_CYCLES 1
`endif

// ===== shared/csa_pkg.sv
package csa_pkg;
  typedef enum logic [3:0] {
    CSA_OP_NOP = 4'h0,
    CSA_OP_ADD = 4'h1,
    CSA_OP_ADC = 4'h2,
    CSA_OP_SUB = 4'h3,
    CSA_OP_SBC = 4'h4,
    CSA_OP_AND = 4'h5,
    CSA_OP_OR = 4'h6,
    CSA_OP_XOR = 4'h7,
    CSA_OP_RLC = 4'h8,
    CSA_OP_RRC = 4'h9,
    CSA_OP_LDA = 4'hA,
    CSA_OP_STA = 4'hB,
    CSA_OP_CLRWDT = 4'hC,
    CSA_OP_HALT = 4'hD
  } csa_op_e;

  typedef struct packed {
    logic ov;
    logic z;
    logic ac;
    logic c;
  } csa_flags_s;

  typedef struct packed {
    logic [7:0] res;
    logic wr_acc;
    csa_flags_s flags;
    csa_flags_s upd;
  } csa_alu_s;
endpackage

// ===== hdl/csa_alu.sv
`timescale 1ns/1ps
`default_nettype none
module csa_alu (
  input wire csa_pkg::csa_op_e i_op,
  input wire logic [7:0] i_a,
  input wire logic [7:0] i_m,
  input wire logic i_c,
  output var csa_pkg::csa_alu_s o_out
);
  logic [7:0] opb;
  logic cin;
  logic [8:0] sum9;
  logic [4:0] low5;
  logic [7:0] low8;
  logic is_arith;

  always_comb begin
    is_arith = 1'b1;
    opb = i_m;
    cin = 1'b0;
    case (i_op)
      csa_pkg::CSA_OP_ADD: cin = 1'b0;
      csa_pkg::CSA_OP_ADC: cin = i_c;
      csa_pkg::CSA_OP_SUB: begin
        opb = ~i_m;
        cin = 1'b1;
      end
      csa_pkg::CSA_OP_SBC: begin
        opb = ~i_m;
        cin = i_c;
      end
      default: is_arith = 1'b0;
    endcase
    // subtraction as a + ~m + 1: carry out means no borrow
    sum9 = {1'b0, i_a} + {1'b0, opb} + {8'h00, cin}; // [RL15]
    low5 = {1'b0, i_a[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin}; // [RL16]
    low8 = {1'b0, i_a[6:0]} + {1'b0, opb[6:0]} + {7'h00, cin};
  end

  always_comb begin
    o_out = '0;
    o_out.flags.c = i_c;
    case (i_op)
      csa_pkg::CSA_OP_ADD, csa_pkg::CSA_OP_ADC,
      csa_pkg::CSA_OP_SUB, csa_pkg::CSA_OP_SBC: begin
        o_out.res = sum9[7:0];
        o_out.flags.c = sum9[8]; // [RL15]
        o_out.flags.ac = low5[4]; // [RL16]
        o_out.flags.ov = low8[7] ^ sum9[8]; // [RL13]
        o_out.upd = 4'hF; // [RL12]
      end
      csa_pkg::CSA_OP_AND: o_out.res = i_a & i_m;
      csa_pkg::CSA_OP_OR: o_out.res = i_a | i_m;
      csa_pkg::CSA_OP_XOR: o_out.res = i_a ^ i_m;
      csa_pkg::CSA_OP_RLC: begin
        o_out.res = {i_a[6:0], i_c};
        o_out.flags.c = i_a[7]; // [RL15]
      end
      csa_pkg::CSA_OP_RRC: begin
        o_out.res = {i_c, i_a[7:1]};
        o_out.flags.c = i_a[0]; // [RL15]
      end
      csa_pkg::CSA_OP_LDA: o_out.res = i_m;
      default: o_out.res = i_a;
    endcase
    case (i_op)
      csa_pkg::CSA_OP_AND, csa_pkg::CSA_OP_OR,
      csa_pkg::CSA_OP_XOR: o_out.upd.z = 1'b1; // [RL12]
      csa_pkg::CSA_OP_RLC, csa_pkg::CSA_OP_RRC: o_out.upd.c = 1'b1;
      default: o_out.upd.z = o_out.upd.z;
    endcase
    o_out.flags.z = (o_out.res == 8'h00); // [RL14]
    // every result goes to the accumulator, never straight to memory
    o_out.wr_acc = is_arith || (i_op inside {csa_pkg::CSA_OP_AND,
      csa_pkg::CSA_OP_OR, csa_pkg::CSA_OP_XOR, csa_pkg::CSA_OP_RLC,
      csa_pkg::CSA_OP_RRC, csa_pkg::CSA_OP_LDA}); // [RL1]
  end
endmodule
`default_nettype wire

// ===== tb/csa_core_sva.sv
`timescale 1ns/1ps
`default_nettype none
module csa_core_sva #(
  parameter int PC_W = 11,
  parameter int GP_DEPTH = 32
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [8:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic i_step,
  input wire logic i_wdt_timeout,
  input wire logic [PC_W-1:0] o_pc,
  input wire logic o_dummy,
  input wire logic [7:0] o_acc,
  input wire logic [7:0] o_status
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // a write or command takes effect only at the acked edge
  logic commit;
  assign commit = i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack;
  a_ack_once: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  a_ack_req: assert property (
    i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("no ack after request");
  a_top_zero: assert property (o_status[7:6] == 2'b00)
    else $error("flag bits 7:6 not zero");
  a_to_set: assert property (i_wdt_timeout |=> o_status[5])
    else $error("timeout did not set flag");
  a_to_hold: assert property (
    !commit && !i_wdt_timeout |=> $stable(o_status[5]))
    else $error("watchdog flag changed");
  a_sys_keep: assert property (
    commit && i_wb_adr[8:2] == 7'h0A && !i_wdt_timeout
    |=> $stable(o_status[5:4]))
    else $error("flag write moved system flags");
  a_pdf_hold: assert property (!commit |=> $stable(o_status[4]))
    else $error("sleep flag changed");
  a_dummy_src: assert property (o_dummy |-> $past(i_step))
    else $error("dummy without step");
  a_dummy_pc: assert property (
    o_dummy && !$past(commit) |-> $stable(o_pc))
    else $error("pc moved in dummy cycle");
  a_acc_src: assert property (!commit |=> $stable(o_acc))
    else $error("accumulator changed without access");
  a_rd_high: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h0)
    else $error("read data upper bits set");
  c_cmd: cover property (commit && i_wb_adr[8:2] == 7'h60);
  c_dummy: cover property (o_dummy);
  c_tmo: cover property (i_wdt_timeout);
endmodule
bind csa_core csa_core_sva #(.PC_W(PC_W), .GP_DEPTH(GP_DEPTH)) u_sva (
  .i_clk, .i_rst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel,
  .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_step, .i_wdt_timeout, .o_pc,
  .o_dummy, .o_acc, .o_status);
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic i_clk = 1'b0, i_rst = 1'b1, i_wb_cyc = 1'b0, i_wb_stb = 1'b0;
  logic i_wb_we = 1'b0, i_step = 1'b0, i_wdt_timeout = 1'b0, o_wb_ack;
  logic [8:0] i_wb_adr = 9'h0;
  logic [3:0] i_wb_sel = 4'hF;
  logic [31:0] i_wb_dat = 32'h0, o_wb_dat, rd;
  logic [10:0] o_pc;
  logic o_dummy;
  logic [7:0] o_acc, o_status;
  logic [15:0] seed = 16'hAF57;
  int miscompares = 0, n_tests = 0, cycles = 0;
  csa_core dut (.i_clk, .i_rst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
    .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_step, .i_wdt_timeout,
    .o_pc, .o_dummy, .o_acc, .o_status);
  always #10 i_clk = ~i_clk;
  function automatic logic [15:0] lfsr(logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // returns {flags, result}; flags not touched by an op keep f
  function automatic logic [11:0] model(logic [3:0] op, logic [7:0] a, m,
                                       logic [3:0] f);
    logic [7:0] b, r;
    logic ci;
    logic [8:0] s;
    logic [3:0] n;
    b = (op >= 3) ? ~m : m;
    ci = (op == 1) ? 1'b0 : (op == 3) ? 1'b1 : f[0];
    s = a + b + ci;
    n = f;
    r = s[7:0];
    if (op <= 4) begin
      n[0] = s[8];
      n[1] = (a[3:0] + b[3:0] + ci) > 15;
      n[3] = ((a[6:0] + b[6:0] + ci) > 127) ^ s[8];
    end else if (op == 5) r = a & m;
    else if (op == 6) r = a | m;
    else if (op == 7) r = a ^ m;
    else if (op == 8) begin
      r = {a[6:0], f[0]};
      n[0] = a[7];
    end else begin
      r = {f[0], a[7:1]};
      n[0] = a[0];
    end
    if (op <= 7) n[2] = (r == 8'h00);
    return {n, r};
  endfunction
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wb(logic we, logic [6:0] idx, logic [31:0] d);
    @(posedge i_clk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= we;
    i_wb_adr <= {idx, 2'b00};
    i_wb_dat <= d;
    do @(posedge i_clk);
    while (!o_wb_ack);
    rd = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
  endtask
  task automatic rdc(string name, logic [6:0] idx, logic [7:0] exp);
    wb(1'b0, idx, 32'h0);
    chk(name, rd, {24'h0, exp});
  endtask
  task automatic pulse(logic tmo);
    @(posedge i_clk);
    if (tmo) i_wdt_timeout <= 1'b1;
    else i_step <= 1'b1;
    @(posedge i_clk);
    i_wdt_timeout <= 1'b0;
    i_step <= 1'b0;
    @(posedge i_clk);
  endtask
  always @(posedge i_clk) begin
    cycles++;
    if (cycles > 4000) begin
      miscompares++;
      results();
    end
  end
  initial begin
    logic [3:0] op, f;
    logic [7:0] a, m;
    logic [11:0] e;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    rdc("status_rst", 7'h0A, 8'h00);
    for (int k = 0; k < 27; k++) begin
      op = 4'(k % 9 + 1);
      seed = lfsr(seed);
      a = seed[7:0];
      m = seed[15:8];
      seed = lfsr(seed);
      f = seed[3:0];
      // corner cases: signed wrap, zero with carry, equal subtract
      if (k == 0) {a, m} = 16'h7F01;
      if (k == 9) {a, m} = 16'hFF01;
      if (k == 20) a = m;
      wb(1'b1, 7'h0A, {28'h0, f});
      wb(1'b1, 7'h05, {24'h0, a});
      wb(1'b1, 7'h40, {24'h0, m});
      wb(1'b1, 7'h60, {17'h0, 7'h40, 4'h0, op});
      e = model(op, a, m, f);
      rdc("acc", 7'h05, e[7:0]);
      rdc("flags", 7'h0A, {4'h0, e[11:8]});
    end
    wb(1'b1, 7'h41, 32'h3C);
    wb(1'b1, 7'h60, 32'h410A);
    wb(1'b1, 7'h60, 32'h420B);
    rdc("move", 7'h42, 8'h3C);
    // a write with byte lane 0 off must leave the accumulator alone
    i_wb_sel <= 4'hE;
    wb(1'b1, 7'h05, 32'h77);
    i_wb_sel <= 4'hF;
    rdc("sel_ign", 7'h05, 8'h3C);
    wb(1'b1, 7'h0A, 32'h0);
    wb(1'b1, 7'h60, 32'hD);
    rdc("halt", 7'h0A, 8'h10);
    wb(1'b1, 7'h0A, 32'hFF);
    rdc("st_wr", 7'h0A, 8'h1F);
    pulse(1'b1);
    rdc("tmo", 7'h0A, 8'h3F);
    wb(1'b1, 7'h60, 32'hD);
    rdc("halt2", 7'h0A, 8'h1F);
    wb(1'b1, 7'h60, 32'hC);
    rdc("clrwdt", 7'h0A, 8'h0F);
    rdc("unmapped", 7'h20, 8'h00);
    wb(1'b1, 7'h01, 32'h41);
    wb(1'b1, 7'h00, 32'h5A);
    rdc("indirect", 7'h41, 8'h5A);
    wb(1'b1, 7'h04, 32'h1);
    wb(1'b1, 7'h03, 32'h41);
    wb(1'b1, 7'h02, 32'hC3);
    rdc("bank1", 7'h02, 8'hC3);
    rdc("bank0", 7'h41, 8'h5A);
    @(posedge i_clk);
    i_step <= 1'b1;
    repeat (260) @(posedge i_clk);
    i_step <= 1'b0;
    wb(1'b1, 7'h06, 32'hA5);
    @(posedge i_clk);
    chk("pc_jump", 32'(o_pc), 32'h1A5);
    pulse(1'b0);
    chk("dummy", 32'(o_dummy), 32'h1);
    chk("pc_hold", 32'(o_pc), 32'h1A5);
    pulse(1'b0);
    chk("pc_next", 32'(o_pc), 32'h1A6);
    results();
  end
endmodule
`default_nettype wire
